// ==== hdl/intr_agg_pkg.sv ====
// Constants, types and register map for the engine interrupt aggregator
package intr_agg_pkg;
  // Structure sizes
  localparam int NUM_SLOTS = 64;
  localparam int GROUP_W   = 32;
  localparam int NUM_GROUP = 2;
  localparam int EVT_W     = 16;
  localparam int NUM_CLASS = 8;
  localparam int MISC_INST = 8;
  localparam int NUM_VF    = 8;
  localparam int ADR_W     = 12;
  localparam int DAT_W     = 32;
  localparam int SLOT_W    = 6;
  localparam int INST_LO_W = 3;

  // Engine class codes
  localparam logic [2:0] CLASS_RENDER  = 3'h0;
  localparam logic [2:0] CLASS_VDECODE = 3'h1;
  localparam logic [2:0] CLASS_VENH    = 3'h2;
  localparam logic [2:0] CLASS_COPY    = 3'h3;
  localparam logic [2:0] CLASS_MISC    = 3'h4;
  localparam logic [2:0] CLASS_COMPUTE = 3'h5;
  localparam logic [2:0] CLASS_LAST    = CLASS_COMPUTE;

  // Interrupt message as delivered by an engine
  typedef struct packed {
    logic [1:0]  rsv_hi;
    logic [2:0]  virtual_function_number;
    logic        rsv_26;
    logic [5:0]  engine_instance_code;
    logic        rsv_19;
    logic [2:0]  engine_class_code;
    logic [15:0] event_bits;
  } intr_msg_t;

  // Register byte offsets
  localparam logic [ADR_W-1:0] MASTER_BASE   = 12'h000;
  localparam logic [ADR_W-1:0] PEND0_ADR     = 12'h040;
  localparam logic [ADR_W-1:0] PEND1_ADR     = 12'h044;
  localparam logic [ADR_W-1:0] SEL0_ADR      = 12'h048;
  localparam logic [ADR_W-1:0] SEL1_ADR      = 12'h04C;
  localparam logic [ADR_W-1:0] SHARED_ADR    = 12'h050;
  localparam logic [ADR_W-1:0] SCHED_ADR     = 12'h060;
  localparam logic [ADR_W-1:0] CLASS_EN_BASE = 12'h100;
  localparam logic [ADR_W-1:0] MISC_EN_BASE  = 12'h120;
  localparam logic [ADR_W-1:0] MASK_BASE     = 12'h200;

  // Field positions
  localparam int MASTER_EN_BIT    = 31;
  localparam int MASTER_DISP_BIT  = 2;
  localparam int SHARED_VALID_BIT = 31;
  localparam int SCHED_MODE_BIT   = 0;
  localparam int SEL_LANE_VALID   = 3;

  // Reset values
  localparam logic [EVT_W-1:0] MASK_RST = 16'hFFFF;
  localparam logic [EVT_W-1:0] EN_RST   = 16'h0000;
endpackage : intr_agg_pkg

// ==== hdl/gpu_engine_interrupt_aggregator.sv ====
// Engine interrupt aggregation with Wishbone register access
//
// Functional notes
// R1: Message holds VF number 29:27, instance 25:20, class 18:16, events 15:0.
// R2: Class codes: render 0, decode 1, enhance 2, copy 3, misc 4, compute 5.
// R3: Engines send at most 16 event bits, always tagged with class and instance.
// R4: Incoming events are ANDed with enables; disabled events are dropped.
// R5: One enable per class, except misc class which has one per instance.
// R6: Enabled events collect in per-instance collapsing storage, not readable.
// R7: Per-instance masks hold masked events until unmasked.
// R8: Unmasked collapsed bits OR into one second-level bit per engine.
// R9: Second-level bits group 32 per word, each group ORed into one event.
// R10: Pending word freezes on read; new events go to secondary storage meanwhile.
// R11: Write ones clears; full clear with secondary events raises a new event.
// R12: Selector write loads unmasked engine bits into shared register with valid MSB.
// R13: Writing one to valid bit clears shared register and selector.
// R14: Software writes one-hot selector matching a bit of its read snapshot.
// R15: Software services engine via selector before clearing its pending bit.
// R16: Master register shows two graphics levels plus display, one per VM.
// R17: Master graphics bits follow group OR and read zero once cleared.
// R18: Interrupt to driver while any master bit set and enable set.
// R19: Software clears enable, reads master once, services, then re-enables.
// R20: Two group events go to the scheduler as two separate vectors.
// R21: Hardware scheduling mode routes group events to scheduler, not host.
// R22: Host and scheduler class enables are preferably complements; the code has a single set of class enables shared by both.
// R23: End of service removes delivered bits, keeping events that arrived later.
`timescale 1ns/10ps
module gpu_engine_interrupt_aggregator (
  // Clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_i,
  // Wishbone slave
  input  wire logic                                 cyc_i,
  input  wire logic                                 stb_i,
  input  wire logic                                 we_i,
  input  wire logic [intr_agg_pkg::ADR_W-1:0]       adr_i,
  input  wire logic [intr_agg_pkg::DAT_W-1:0]       dat_i,
  input  wire logic [3:0]                           sel_i,
  output logic      [intr_agg_pkg::DAT_W-1:0]       dat_o,
  output logic                                      ack_o,
  // Engine messages
  input  wire logic                                 msg_valid_i,
  input  wire intr_agg_pkg::intr_msg_t              msg_i,
  // Display level
  input  wire logic                                 display_irq_i,
  // Interrupt outputs
  output logic      [intr_agg_pkg::NUM_VF-1:0]      host_irq_o,
  output logic      [intr_agg_pkg::NUM_GROUP-1:0]   sched_vector_o
);

  localparam int SW = intr_agg_pkg::SLOT_W;
  localparam int EW = intr_agg_pkg::EVT_W;
  localparam int GW = intr_agg_pkg::GROUP_W;
  localparam int IW = intr_agg_pkg::INST_LO_W;

  logic                                   ack_q;
  logic [intr_agg_pkg::DAT_W-1:0]         dat_q;
  logic [intr_agg_pkg::DAT_W-1:0]         rdata;
  logic [intr_agg_pkg::DAT_W-1:0]         wmask;
  logic [intr_agg_pkg::DAT_W-1:0]         wbits;
  logic                                   req;
  logic                                   wr;
  logic                                   rd;
  logic [EW-1:0]                          collapse_q [intr_agg_pkg::NUM_SLOTS];
  logic [EW-1:0]                          mask_q     [intr_agg_pkg::NUM_SLOTS];
  logic [EW-1:0]                          class_en_q [intr_agg_pkg::NUM_CLASS];
  logic [EW-1:0]                          misc_en_q  [intr_agg_pkg::MISC_INST];
  logic [intr_agg_pkg::NUM_SLOTS-1:0]     level2;
  logic [GW-1:0]                          snap_q     [intr_agg_pkg::NUM_GROUP];
  logic [GW-1:0]                          sec_q      [intr_agg_pkg::NUM_GROUP];
  logic [intr_agg_pkg::NUM_GROUP-1:0]     frozen_q;
  logic [intr_agg_pkg::NUM_GROUP-1:0]     dw_level;
  logic [intr_agg_pkg::NUM_GROUP-1:0]     dw_prev_q;
  logic [intr_agg_pkg::NUM_GROUP-1:0]     sched_q;
  logic [intr_agg_pkg::NUM_SLOTS-1:0]     sel_q;
  logic [SW-1:0]                          svc_slot_q;
  logic [EW-1:0]                          shared_bits_q;
  logic                                   shared_valid_q;
  logic                                   hw_sched_q;
  logic [intr_agg_pkg::NUM_VF-1:0]        master_en_q;
  logic [intr_agg_pkg::NUM_VF-1:0]        host_irq_q;
  logic [intr_agg_pkg::MASTER_DISP_BIT:0] master_bits;
  logic                                   in_ok;
  logic [SW-1:0]                          in_slot;
  logic [EW-1:0]                          in_en;
  logic [EW-1:0]                          in_bits;
  logic                                   svc_clear;
  logic                                   sel_wr;
  logic                                   sel_grp;
  logic [GW-1:0]                          sel_data;
  logic [SW-1:0]                          sel_slot;
  logic                                   hit_mask;
  logic                                   hit_class;
  logic                                   hit_misc;
  logic                                   hit_master;

  // Lowest set bit of a selector word
  function automatic logic [4:0] first_set(input logic [GW-1:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = GW - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : first_set

  // Bus decode
  assign req   = cyc_i & stb_i & ~ack_q;
  assign wr    = req & we_i;
  assign rd    = req & ~we_i;
  assign wbits = dat_i & wmask;
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  for (genvar l = 0; l < 4; l++) begin : g_lane
    assign wmask[8*l +: 8] = {8{sel_i[l]}};
  end

  assign hit_mask   = adr_i[11:8] == intr_agg_pkg::MASK_BASE[11:8];
  assign hit_class  = adr_i[11:5] == intr_agg_pkg::CLASS_EN_BASE[11:5];
  assign hit_misc   = adr_i[11:5] == intr_agg_pkg::MISC_EN_BASE[11:5];
  assign hit_master = adr_i[11:5] == intr_agg_pkg::MASTER_BASE[11:5];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Message field extraction and enable gating
  assign in_slot = {msg_i.engine_class_code, msg_i.engine_instance_code[IW-1:0]}; // see R1
  assign in_ok   = msg_valid_i
                 & (msg_i.engine_class_code <= intr_agg_pkg::CLASS_LAST)
                 & (msg_i.engine_instance_code[5:IW] == 3'h0); // see R2
  assign in_en   = (msg_i.engine_class_code == intr_agg_pkg::CLASS_MISC)
                 ? misc_en_q[msg_i.engine_instance_code[IW-1:0]]
                 : class_en_q[msg_i.engine_class_code]; // see R5
  assign in_bits = in_ok ? (msg_i.event_bits & in_en) : '0; // see R4

  // End of service for the selected engine
  assign svc_clear = wr & (adr_i == intr_agg_pkg::SHARED_ADR) & sel_i[intr_agg_pkg::SEL_LANE_VALID]
                   & dat_i[intr_agg_pkg::SHARED_VALID_BIT] & shared_valid_q; // see R13

  // Per-engine collapsing storage and masks
  for (genvar s = 0; s < intr_agg_pkg::NUM_SLOTS; s++) begin : g_slot
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        collapse_q[s] <= '0;
      end else begin
        collapse_q[s] <= (collapse_q[s] & ~((svc_clear && svc_slot_q == SW'(s)) ? shared_bits_q : '0))
                       | ((in_slot == SW'(s)) ? in_bits : '0); // see R6, R23
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mask_q[s] <= intr_agg_pkg::MASK_RST;
      end else if (wr && hit_mask && adr_i[7:2] == SW'(s)) begin
        mask_q[s] <= (mask_q[s] & ~wmask[EW-1:0]) | wbits[EW-1:0]; // see R7
      end
    end

    assign level2[s] = |(collapse_q[s] & ~mask_q[s]); // see R7, R8
  end

  // Class and misc-instance enables
  for (genvar c = 0; c < intr_agg_pkg::NUM_CLASS; c++) begin : g_en
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        class_en_q[c] <= intr_agg_pkg::EN_RST;
      end else if (wr && hit_class && adr_i[4:2] == 3'(c)) begin
        class_en_q[c] <= (class_en_q[c] & ~wmask[EW-1:0]) | wbits[EW-1:0]; // see R5
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        misc_en_q[c] <= intr_agg_pkg::EN_RST;
      end else if (wr && hit_misc && adr_i[4:2] == 3'(c)) begin
        misc_en_q[c] <= (misc_en_q[c] & ~wmask[EW-1:0]) | wbits[EW-1:0]; // see R5
      end
    end
  end

  // Double-buffered second-level pending, one per group
  for (genvar g = 0; g < intr_agg_pkg::NUM_GROUP; g++) begin : g_grp
    logic [intr_agg_pkg::ADR_W-1:0] pend_adr;
    logic [GW-1:0]                  clr;
    logic [GW-1:0]                  ev;
    logic [GW-1:0]                  left;
    logic                           rd_pend;

    assign pend_adr = g ? intr_agg_pkg::PEND1_ADR : intr_agg_pkg::PEND0_ADR;
    assign clr      = (wr && adr_i == pend_adr) ? wbits : '0; // see R11
    assign ev       = level2[g*GW +: GW]; // see R9
    assign left     = snap_q[g] & ~clr;
    assign rd_pend  = rd && adr_i == pend_adr;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        snap_q[g]   <= '0;
        sec_q[g]    <= '0;
        frozen_q[g] <= 1'b0;
      end else if (frozen_q[g]) begin
        // Only engines outside what remains of the snapshot after this write's clear count as new
        sec_q[g] <= sec_q[g] | (ev & ~left); // see R10
        if (left == '0) begin
          snap_q[g]   <= '0; // see R11
          frozen_q[g] <= 1'b0;
        end else begin
          snap_q[g] <= left;
        end
      end else if (rd_pend) begin
        frozen_q[g] <= 1'b1; // see R10
        sec_q[g]    <= sec_q[g] | (ev & ~left);
      end else begin
        snap_q[g] <= left | sec_q[g] | ev; // see R11
        sec_q[g]  <= '0;
      end
    end

    assign dw_level[g] = |snap_q[g]; // see R9
  end

  // Group event edges toward the scheduler
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dw_prev_q <= '0;
      sched_q   <= '0;
    end else begin
      dw_prev_q <= dw_level;
      sched_q   <= hw_sched_q ? (dw_level & ~dw_prev_q) : '0; // see R20, R21
    end
  end
  assign sched_vector_o = sched_q;

  // Selector and shared pending register
  assign sel_grp  = adr_i == intr_agg_pkg::SEL1_ADR;
  assign sel_data = wbits;
  assign sel_wr   = wr & (adr_i == intr_agg_pkg::SEL0_ADR | sel_grp) & (|sel_data) & ~shared_valid_q;
  assign sel_slot = {sel_grp, first_set(sel_data)};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q          <= '0;
      svc_slot_q     <= '0;
      shared_bits_q  <= '0;
      shared_valid_q <= 1'b0;
    end else if (svc_clear) begin
      sel_q          <= '0; // see R13
      shared_bits_q  <= '0;
      shared_valid_q <= 1'b0;
    end else if (sel_wr) begin
      sel_q          <= sel_grp ? {sel_data, {GW{1'b0}}} : {{GW{1'b0}}, sel_data};
      svc_slot_q     <= sel_slot;
      shared_bits_q  <= collapse_q[sel_slot] & ~mask_q[sel_slot]; // see R12
      shared_valid_q <= 1'b1;
    end
  end

  // Scheduling mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hw_sched_q <= 1'b0;
    end else if (wr && adr_i == intr_agg_pkg::SCHED_ADR && sel_i[0]) begin
      hw_sched_q <= dat_i[intr_agg_pkg::SCHED_MODE_BIT];
    end
  end

  // Master control, one copy per virtual machine
  assign master_bits = {display_irq_i, hw_sched_q ? 2'b00 : dw_level}; // see R16, R17, R21

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_en_q <= '0;
    end else if (wr && hit_master && sel_i[intr_agg_pkg::SEL_LANE_VALID]) begin
      master_en_q[adr_i[4:2]] <= dat_i[intr_agg_pkg::MASTER_EN_BIT]; // see R16
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_irq_q <= '0;
    end else begin
      host_irq_q <= master_en_q & {intr_agg_pkg::NUM_VF{|master_bits}}; // see R18
    end
  end
  assign host_irq_o = host_irq_q;

  // Read multiplexer
  always_comb begin
    rdata = '0;
    if (hit_master) begin
      rdata[intr_agg_pkg::MASTER_EN_BIT] = master_en_q[adr_i[4:2]];
      rdata[intr_agg_pkg::MASTER_DISP_BIT:0] = master_bits; // see R17
    end else if (hit_class) begin
      rdata[EW-1:0] = class_en_q[adr_i[4:2]];
    end else if (hit_misc) begin
      rdata[EW-1:0] = misc_en_q[adr_i[4:2]];
    end else if (hit_mask) begin
      rdata[EW-1:0] = mask_q[adr_i[7:2]];
    end else begin
      unique case (adr_i)
        intr_agg_pkg::PEND0_ADR:  rdata = snap_q[0];
        intr_agg_pkg::PEND1_ADR:  rdata = snap_q[1];
        intr_agg_pkg::SEL0_ADR:   rdata = sel_q[GW-1:0];
        intr_agg_pkg::SEL1_ADR:   rdata = sel_q[2*GW-1:GW];
        intr_agg_pkg::SHARED_ADR: begin
          rdata[intr_agg_pkg::SHARED_VALID_BIT] = shared_valid_q;
          rdata[EW-1:0] = shared_bits_q;
        end
        intr_agg_pkg::SCHED_ADR:  rdata[intr_agg_pkg::SCHED_MODE_BIT] = hw_sched_q;
        default:                  rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (rd) begin
      dat_q <= rdata;
    end
  end

endmodule : gpu_engine_interrupt_aggregator

// ==== verif/intr_agg_properties.sv ====
// Port-level checks for the engine interrupt aggregator
`timescale 1ns/10ps
module intr_agg_properties (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Interrupt side
  input wire logic        display_irq_i,
  input wire logic [7:0]  host_irq_o,
  input wire logic [1:0]  sched_vector_o
);
  logic [7:0] en_h;
  logic       hw_h;
  wire        take = cyc_i && stb_i && !ack_o;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Shadow of the per-VM master enables
  always_ff @(posedge clk_i)
    if (rst_i) en_h <= 8'h00;
    else if (take && we_i && sel_i[3] && adr_i[11:5] == 7'h00) en_h[adr_i[4:2]] <= dat_i[31];

  // Shadow of the scheduling mode
  always_ff @(posedge clk_i)
    if (rst_i) hw_h <= 1'b0;
    else if (take && we_i && sel_i[0] && adr_i == intr_agg_pkg::SCHED_ADR) hw_h <= dat_i[0];

  ack_latency_a : assert property (take |=> ack_o)
    else $error("request not acknowledged next cycle");
  ack_pulse_a : assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  unmapped_zero_a : assert property (take && !we_i && adr_i[11:10] != 2'h0 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  read_hold_a : assert property (!(take && !we_i) |=> $stable(dat_o))
    else $error("read data changed without a read");
  irq_enable_a : assert property ((host_irq_o & ~$past(en_h)) == 8'h00)
    else $error("host interrupt without master enable");
  irq_display_a : assert property (display_irq_i [*2] |=> host_irq_o == $past(en_h))
    else $error("display level not reported to enabled hosts");
  host_quiet_a : assert property ((!display_irq_i && hw_h) [*2] |=> host_irq_o == 8'h00)
    else $error("host interrupted in scheduler mode");
  vector_pulse_a : assert property (sched_vector_o != 2'h0 |=> (sched_vector_o & $past(sched_vector_o)) == 2'h0)
    else $error("scheduler vector longer than one cycle");
  vector_mode_a : assert property (sched_vector_o != 2'h0 |-> hw_h || $past(hw_h))
    else $error("scheduler vector outside scheduler mode");
endmodule : intr_agg_properties

bind gpu_engine_interrupt_aggregator intr_agg_properties props_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
  .display_irq_i(display_irq_i), .host_irq_o(host_irq_o), .sched_vector_o(sched_vector_o));

// ==== verif/engine_source_model.sv ====
// Behavioural engine issuing tagged interrupt messages
`timescale 1ns/10ps
module engine_source_model (
  // Clock
  input  wire logic                   clk_i,
  // Message output
  output logic                        msg_valid_o,
  output intr_agg_pkg::intr_msg_t     msg_o
);
  initial begin
    msg_valid_o = 1'b0;
    msg_o       = '0;
  end

  task automatic send(input logic [2:0] cls, input logic [5:0] inst, input logic [15:0] bits);
    msg_o       <= {2'h0, 3'h5, 1'b0, inst, 1'b0, cls, bits};
    msg_valid_o <= 1'b1;
    @(posedge clk_i);
    msg_valid_o <= 1'b0;
    // Stale message bits must not linger
    msg_o       <= ~msg_o;
    @(posedge clk_i);
  endtask : send
endmodule : engine_source_model

// ==== verif/tb.sv ====
// Self-checking bench for the engine interrupt aggregator
`timescale 1ns/10ps
module tb;
  logic                    clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, display_irq_i = 1'b0;
  logic [11:0]             adr_i = 12'h000;
  logic [31:0]             dat_i = 32'h0, dat_o, q;
  logic [3:0]              sel_i = 4'hF;
  logic                    ack_o, msg_valid_i;
  logic [7:0]              host_irq_o;
  logic [1:0]              sched_vector_o;
  intr_agg_pkg::intr_msg_t msg_i;
  int                      err_count = 0, num_checks = 0, cycles = 0, pulses [2] = '{0, 0};

  gpu_engine_interrupt_aggregator dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .msg_valid_i(msg_valid_i),
    .msg_i(msg_i), .display_irq_i(display_irq_i), .host_irq_o(host_irq_o), .sched_vector_o(sched_vector_o));
  engine_source_model src_u (.clk_i(clk_i), .msg_valid_o(msg_valid_i), .msg_o(msg_i));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    for (int g = 0; g < 2; g++) if (sched_vector_o[g] === 1'b1) pulses[g]++;
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    check({31'h0, ack_o}, 32'h0, "ack drop");
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(q, exp, what);
  endtask : rd

  // One selector and shared-register round, then the pending clear
  task automatic svc(input logic [11:0] g, input logic [31:0] s, input logic [31:0] exp);
    wr(intr_agg_pkg::SEL0_ADR + g, s);
    rd(intr_agg_pkg::SHARED_ADR, exp, "shared");
    wr(intr_agg_pkg::SHARED_ADR, 32'h80000000);
    wr(intr_agg_pkg::PEND0_ADR + g, s);
    repeat (4) @(posedge clk_i);
  endtask : svc

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(intr_agg_pkg::MASK_BASE, 32'h0000FFFF, "mask reset");
    rd(intr_agg_pkg::CLASS_EN_BASE, 32'h0, "enable reset");
    wr(12'h400, 32'hFFFFFFFF);
    rd(12'h400, 32'h0, "unmapped");
    $display("reset test done");
    wr(intr_agg_pkg::CLASS_EN_BASE, 32'h00F0);
    wr(intr_agg_pkg::MASK_BASE, 32'h0);
    src_u.send(intr_agg_pkg::CLASS_RENDER, 6'h00, 16'h000F);
    repeat (4) @(posedge clk_i);
    rd(intr_agg_pkg::MASTER_BASE, 32'h0, "disabled");
    src_u.send(intr_agg_pkg::CLASS_RENDER, 6'h00, 16'h0030);
    repeat (4) @(posedge clk_i);
    rd(intr_agg_pkg::MASTER_BASE, 32'h1, "level");
    rd(intr_agg_pkg::PEND0_ADR, 32'h1, "snapshot");
    wr(intr_agg_pkg::CLASS_EN_BASE + 12'h00C, 32'hFFFF);
    wr(intr_agg_pkg::MASK_BASE + 12'h060, 32'h0);
    src_u.send(intr_agg_pkg::CLASS_COPY, 6'h00, 16'h0100);
    repeat (4) @(posedge clk_i);
    rd(intr_agg_pkg::PEND0_ADR, 32'h1, "frozen");
    wr(intr_agg_pkg::SEL0_ADR, 32'h1);
    rd(intr_agg_pkg::SHARED_ADR, 32'h80000030, "shared");
    src_u.send(intr_agg_pkg::CLASS_RENDER, 6'h00, 16'h0040);
    wr(intr_agg_pkg::SHARED_ADR, 32'h80000000);
    rd(intr_agg_pkg::SEL0_ADR, 32'h0, "selector clear");
    rd(intr_agg_pkg::SHARED_ADR, 32'h0, "shared clear");
    wr(intr_agg_pkg::PEND0_ADR, 32'h1);
    repeat (4) @(posedge clk_i);
    rd(intr_agg_pkg::PEND0_ADR, 32'h01000001, "secondary");
    svc(12'h000, 32'h1, 32'h80000040);
    svc(12'h000, 32'h01000000, 32'h80000100);
    rd(intr_agg_pkg::MASTER_BASE, 32'h0, "cleared");
    $display("pending test done");
    wr(intr_agg_pkg::MASK_BASE, 32'hFFFF);
    src_u.send(intr_agg_pkg::CLASS_RENDER, 6'h00, 16'h0010);
    repeat (4) @(posedge clk_i);
    rd(intr_agg_pkg::MASTER_BASE, 32'h0, "masked");
    wr(intr_agg_pkg::MASK_BASE, 32'h0);
    repeat (4) @(posedge clk_i);
    rd(intr_agg_pkg::PEND0_ADR, 32'h1, "unmasked");
    svc(12'h000, 32'h1, 32'h80000010);
    $display("mask test done");
    wr(intr_agg_pkg::MISC_EN_BASE + 12'h004, 32'hFFFF);
    wr(intr_agg_pkg::MASK_BASE + 12'h084, 32'h0);
    wr(intr_agg_pkg::MASK_BASE + 12'h088, 32'h0);
    wr(intr_agg_pkg::MASK_BASE + 12'h004, 32'h0);
    wr(intr_agg_pkg::MASTER_BASE + 12'h004, 32'h80000000);
    src_u.send(intr_agg_pkg::CLASS_MISC, 6'h02, 16'h0001);
    src_u.send(intr_agg_pkg::CLASS_MISC, 6'h01, 16'h0001);
    src_u.send(intr_agg_pkg::CLASS_RENDER, 6'h01, 16'h0020);
    repeat (4) @(posedge clk_i);
    check({24'h0, host_irq_o}, 32'h2, "irq");
    wr(intr_agg_pkg::MASTER_BASE + 12'h004, 32'h0);
    rd(intr_agg_pkg::MASTER_BASE + 12'h004, 32'h3, "master");
    rd(intr_agg_pkg::PEND1_ADR, 32'h2, "misc");
    svc(12'h004, 32'h2, 32'h80000001);
    rd(intr_agg_pkg::PEND0_ADR, 32'h2, "render 1");
    svc(12'h000, 32'h2, 32'h80000020);
    wr(intr_agg_pkg::MASTER_BASE + 12'h004, 32'h80000000);
    check({24'h0, host_irq_o}, 32'h0, "irq off");
    display_irq_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check({24'h0, host_irq_o}, 32'h2, "display irq");
    rd(intr_agg_pkg::MASTER_BASE + 12'h00C, 32'h4, "display");
    display_irq_i <= 1'b0;
    $display("host test done");
    check(32'(pulses[0] + pulses[1]), 32'h0, "no vector");
    wr(intr_agg_pkg::SCHED_ADR, 32'h1);
    src_u.send(intr_agg_pkg::CLASS_MISC, 6'h01, 16'h0001);
    repeat (4) @(posedge clk_i);
    check(32'(pulses[1]), 32'h1, "vector 1");
    check(32'(pulses[0]), 32'h0, "vector 0");
    rd(intr_agg_pkg::MASTER_BASE + 12'h004, 32'h80000000, "hw master");
    rd(intr_agg_pkg::PEND1_ADR, 32'h2, "hw pending");
    svc(12'h004, 32'h2, 32'h80000001);
    $display("scheduler test done");
    conclude();
  end
endmodule : tb
